/* shared/serial_port_mode_pkg.sv */
// constants and types for the serial control port
// assumes a single system clock and a 24-bit register space
package serial_port_mode_pkg;

    // widths
    localparam int DATA_W = 24;
    localparam int FRAME_W = 32;
    localparam int ADDR_W = 6;
    localparam int MULTI_ADDR_W = 5;
    localparam int CHIP_ADDR_W = 3;
    localparam int CNT_W = 6;
    localparam int REG_COUNT = 64;
    localparam int STROBE_W = 18;

    // register offsets
    localparam logic [5:0] REG_CHIP_IDENTIFIER_AND_STROBE = 6'h00;
    localparam logic [5:0] REG_OSCILLATOR_THREE = 6'h03;

    // field positions
    localparam int BIAS_BIT = 4;
    localparam int SOFT_RESET_BIT = 5;
    localparam int STROBE_LSB = 6;
    localparam int POINTER_LSB = 0;
    localparam int FRAME_DATA_LSB = 8;
    localparam int FRAME_ADDR_LSB = 3;
    localparam int FRAME_CHIP_LSB = 0;

    // reset values; identifier value is arbitrary
    localparam logic [23:0] CHIP_IDENTIFIER = 24'h5ac31e;
    localparam logic [23:0] OSC_THREE_RESET = 24'h000010;
    localparam logic [23:0] REG_RESET = 24'h000000;

    // rising-edge count before the edge (edge n has count n-1)
    localparam logic [5:0] EDGE_RW = 6'h00;
    localparam logic [5:0] EDGE_LAST_ADDR = 6'h06;
    localparam logic [5:0] EDGE_FIRST_DATA = 6'h07;
    localparam logic [5:0] EDGE_LAST_READ = 6'h1e;
    localparam logic [5:0] EDGE_COMMIT = 6'h1f;
    localparam logic [5:0] CNT_SAT = 6'h20;

    typedef enum logic [1:0] {
        MODE_UNDECIDED,
        MODE_LEGACY,
        MODE_MULTI
    } port_mode_t;

endpackage

/* core/serial_port_mode_select.sv */
// serial control port with power-up protocol choice and register 0
// assumes i_rst is the hard (power-on) reset and pins are asynchronous
`timescale 1ns/1ps

module serial_port_mode_select
    import serial_port_mode_pkg::*;
(
    // clock and hard reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // serial pins from the host
    input wire logic i_serial_port_select,
    input wire logic i_serial_clk,
    input wire logic i_serial_data_in,
    // board strap and pll status
    input wire logic [CHIP_ADDR_W-1:0] i_chip_address,
    input wire logic i_lock_detect,
    // serial data out and mode flags
    output logic o_lock_or_read_data_out,
    output logic o_legacy_single_slave_mode,
    output logic o_multi_slave_mode,
    // controls toward the pll core
    output logic o_bias_enable,
    output logic o_soft_reset,
    output logic [STROBE_W-1:0] o_strobes
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic sen_s1, sen_s2, sen_s3;
    logic sck_s1, sck_s2, sck_s3;
    logic sdi_s1, sdi_s2;
    logic [CHIP_ADDR_W-1:0] chip_s1, chip_s2;
    logic sen_rise, sclk_rise;

    // two stages each; third stage only for edge finding
    always_ff @(posedge i_mclk) begin
        sen_s1 <= i_serial_port_select;
        sen_s2 <= sen_s1;
        sen_s3 <= sen_s2;
        sck_s1 <= i_serial_clk;
        sck_s2 <= sck_s1;
        sck_s3 <= sck_s2;
        sdi_s1 <= i_serial_data_in;
        sdi_s2 <= sdi_s1;
        chip_s1 <= i_chip_address;
        chip_s2 <= chip_s1;
    end

    // data shares the clock's delay, so stays aligned with it
    assign sen_rise = sen_s2 & ~sen_s3;
    assign sclk_rise = sck_s2 & ~sck_s3;

    ////////////////////////////////////////////////////////////////////
    // protocol choice

    port_mode_t mode_q;

    // only a hard reset reopens the choice; soft reset cannot
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            mode_q <= MODE_UNDECIDED;
        end else begin
            unique case (mode_q)
                MODE_UNDECIDED: begin
                    if (sen_rise) begin
                        mode_q <= MODE_LEGACY;
                    end else if (sclk_rise) begin
                        mode_q <= MODE_MULTI;
                    end
                end
                MODE_LEGACY: mode_q <= MODE_LEGACY;
                MODE_MULTI: mode_q <= MODE_MULTI;
            endcase
        end
    end

    // flags lag the state by one cycle
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_legacy_single_slave_mode <= 1'b0;
            o_multi_slave_mode <= 1'b0;
        end else begin
            o_legacy_single_slave_mode <= (mode_q == MODE_LEGACY);
            o_multi_slave_mode <= (mode_q == MODE_MULTI);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shifting and frame position

    logic [FRAME_W-1:0] sh_q;
    logic [CNT_W-1:0] cnt_q;
    logic rw_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_in;

    // shifts in every mode, so the deciding clock edge keeps its bit
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sh_q <= '0;
        end else if (sclk_rise) begin
            sh_q <= {sh_q[FRAME_W-2:0], sdi_s2};
        end
    end

    // legacy edge count restarts at each select rise
    always_ff @(posedge i_mclk) begin
        if (i_rst || sen_rise) begin
            cnt_q <= '0;
        end else if (sclk_rise && cnt_q != CNT_SAT) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    assign addr_in = {sh_q[ADDR_W-2:0], sdi_s2};

    // legacy header: one direction bit then six address bits
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rw_q <= 1'b0;
            addr_q <= '0;
        end else if (mode_q == MODE_LEGACY && sclk_rise) begin
            if (cnt_q == EDGE_RW) begin
                rw_q <= sdi_s2;
            end
            if (cnt_q == EDGE_LAST_ADDR) begin
                addr_q <= addr_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write decode

    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic chip_match;
    logic wr_zero;
    logic soft_hit;
    logic [STROBE_W-1:0] wr_strobes;
    logic [MULTI_ADDR_W-1:0] wr_ptr;

    assign chip_match =
        sh_q[FRAME_CHIP_LSB +: CHIP_ADDR_W] == chip_s2;

    // legacy commits on edge 32; multi latches on select rise
    always_comb begin
        wr_en = 1'b0;
        wr_addr = '0;
        wr_data = '0;
        if (mode_q == MODE_LEGACY && sclk_rise &&
            cnt_q == EDGE_COMMIT && !rw_q) begin
            wr_en = 1'b1;
            wr_addr = addr_q;
            // data bits came on rises 8 to 31; the rise-32 bit is unused
            wr_data = sh_q[DATA_W-1:0];
        end else if (mode_q == MODE_MULTI && sen_rise &&
                     chip_match) begin
            wr_en = 1'b1;
            wr_addr = {1'b0, sh_q[FRAME_ADDR_LSB +: MULTI_ADDR_W]};
            wr_data = sh_q[FRAME_DATA_LSB +: DATA_W];
        end
    end

    assign wr_zero = wr_en && wr_addr == REG_CHIP_IDENTIFIER_AND_STROBE;
    assign soft_hit = wr_zero && wr_data[SOFT_RESET_BIT];
    assign wr_strobes = wr_data[STROBE_LSB +: STROBE_W];
    assign wr_ptr = wr_data[POINTER_LSB +: MULTI_ADDR_W];

    ////////////////////////////////////////////////////////////////////
    // register file

    logic [DATA_W-1:0] regs_q [REG_COUNT];

    function automatic logic [DATA_W-1:0] reg_reset(
        input logic [ADDR_W-1:0] a);
        return (a == REG_OSCILLATOR_THREE) ? OSC_THREE_RESET : REG_RESET;
    endfunction

    // register 0 is never stored; it reads as the identifier
    function automatic logic [DATA_W-1:0] reg_read(
        input logic [ADDR_W-1:0] a);
        return (a == REG_CHIP_IDENTIFIER_AND_STROBE) ? CHIP_IDENTIFIER
                                             : regs_q[a];
    endfunction

    // soft reset restores defaults but keeps the protocol choice
    always_ff @(posedge i_mclk) begin
        if (i_rst || soft_hit) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_q[i] <= reg_reset(ADDR_W'(i));
            end
        end else if (wr_en && !wr_zero) begin
            regs_q[wr_addr] <= wr_data;
        end
    end

    // bias mirror drives the output stage directly
    always_ff @(posedge i_mclk) begin
        if (i_rst || soft_hit) begin
            o_bias_enable <= OSC_THREE_RESET[BIAS_BIT];
        end else if (wr_en && wr_addr == REG_OSCILLATOR_THREE) begin
            o_bias_enable <= wr_data[BIAS_BIT];
        end
    end

    // strobes and soft reset are single-cycle pulses
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_soft_reset <= 1'b0;
            o_strobes <= '0;
        end else begin
            o_soft_reset <= soft_hit;
            o_strobes <= wr_zero ? wr_strobes : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // multi-slave read pointer and out shifter

    logic [MULTI_ADDR_W-1:0] ptr_q, ptr_next;
    logic [DATA_W-1:0] mrd_q;

    // pointer only moves in multi mode; legacy ignores the field
    assign ptr_next = (mode_q == MODE_MULTI && wr_zero) ? wr_ptr
                                                         : ptr_q;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ptr_q <= '0;
        end else begin
            ptr_q <= ptr_next;
        end
    end

    // reload at frame end so the next frame shifts the target out
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            mrd_q <= CHIP_IDENTIFIER;
        end else if (mode_q == MODE_MULTI && sen_rise) begin
            mrd_q <= reg_read({1'b0, ptr_next});
        end else if (mode_q != MODE_LEGACY && sclk_rise) begin
            mrd_q <= {mrd_q[DATA_W-2:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data-out pin: lock detect in undecided and legacy mode unless a legacy read owns it; multi mode always shows read data

    logic reading_q;
    logic [DATA_W-1:0] rd_q;

    // without the data-out wire the host simply never sees reads
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            reading_q <= 1'b0;
            rd_q <= '0;
            o_lock_or_read_data_out <= 1'b0;
        end else begin
            unique case (mode_q)
                MODE_LEGACY: begin
                    if (sen_rise) begin
                        reading_q <= 1'b0;
                        o_lock_or_read_data_out <= i_lock_detect;
                    end else if (sclk_rise && cnt_q == EDGE_LAST_ADDR &&
                                 rw_q) begin
                        reading_q <= 1'b1;
                        rd_q <= reg_read(addr_in);
                    end else if (sclk_rise && reading_q &&
                                 cnt_q >= EDGE_FIRST_DATA &&
                                 cnt_q <= EDGE_LAST_READ) begin
                        o_lock_or_read_data_out <= rd_q[DATA_W-1];
                        rd_q <= {rd_q[DATA_W-2:0], 1'b0};
                    end else if (sclk_rise && reading_q &&
                                 cnt_q == EDGE_COMMIT) begin
                        reading_q <= 1'b0;
                        o_lock_or_read_data_out <= i_lock_detect;
                    end else if (!reading_q) begin
                        o_lock_or_read_data_out <= i_lock_detect;
                    end
                end
                MODE_MULTI: begin
                    o_lock_or_read_data_out <= mrd_q[DATA_W-1];
                end
                MODE_UNDECIDED: begin
                    o_lock_or_read_data_out <= i_lock_detect;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    property p_lock_legacy;
        mode_q == MODE_UNDECIDED && sen_rise |=> mode_q == MODE_LEGACY;
    endproperty
    a_lock_legacy: assert property (p_lock_legacy)
        else $error("select edge did not lock legacy mode");

    property p_lock_multi;
        mode_q == MODE_UNDECIDED && sclk_rise && !sen_rise
            |=> mode_q == MODE_MULTI;
    endproperty
    a_lock_multi: assert property (p_lock_multi)
        else $error("clock edge did not lock multi mode");

    property p_mode_held;
        mode_q != MODE_UNDECIDED |=> $stable(mode_q) [*8];
    endproperty
    a_mode_held: assert property (p_mode_held)
        else $error("locked protocol changed");

    property p_listen;
        mode_q == MODE_UNDECIDED && sclk_rise
            |=> sh_q[0] == $past(sdi_s2);
    endproperty
    a_listen: assert property (p_listen)
        else $error("bit lost before protocol choice");

    property p_bias_default;
        $fell(i_rst) |-> o_bias_enable;
    endproperty
    a_bias_default: assert property (p_bias_default)
        else $error("bias not enabled after reset");

    property p_bias_clear;
        wr_en && wr_addr == REG_OSCILLATOR_THREE && !wr_data[BIAS_BIT]
            |=> !o_bias_enable;
    endproperty
    a_bias_clear: assert property (p_bias_clear)
        else $error("bias not disabled by write");

    property p_legacy_commit;
        mode_q == MODE_LEGACY && sclk_rise && cnt_q == EDGE_COMMIT &&
            !rw_q |-> wr_en && wr_addr == addr_q &&
            wr_data == sh_q[DATA_W-1:0];
    endproperty
    a_legacy_commit: assert property (p_legacy_commit)
        else $error("legacy write not committed on edge 32");

    property p_read_id;
        mode_q == MODE_LEGACY && sclk_rise && cnt_q == EDGE_LAST_ADDR &&
            rw_q && addr_in == REG_CHIP_IDENTIFIER_AND_STROBE
            |=> rd_q == CHIP_IDENTIFIER;
    endproperty
    a_read_id: assert property (p_read_id)
        else $error("register 0 read is not the identifier");

    property p_read_restore;
        mode_q == MODE_LEGACY && reading_q && sclk_rise &&
            cnt_q == EDGE_COMMIT
            |=> !reading_q && o_lock_or_read_data_out == $past(i_lock_detect);
    endproperty
    a_read_restore: assert property (p_read_restore)
        else $error("lock detect not restored on edge 32");

    property p_chip_filter;
        mode_q == MODE_MULTI && sen_rise && !chip_match |-> !wr_en;
    endproperty
    a_chip_filter: assert property (p_chip_filter)
        else $error("foreign chip address accepted");

    property p_multi_latch;
        mode_q == MODE_MULTI && sen_rise && chip_match
            |-> wr_en && !wr_addr[ADDR_W-1];
    endproperty
    a_multi_latch: assert property (p_multi_latch)
        else $error("multi frame not latched on select rise");

    property p_strobe;
        wr_zero |=> o_strobes == $past(wr_strobes) &&
            o_soft_reset == $past(soft_hit) ##1 o_strobes == '0;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("register 0 write pulses wrong");

    property p_pointer;
        mode_q == MODE_MULTI && wr_zero |=> ptr_q == $past(wr_ptr);
    endproperty
    a_pointer: assert property (p_pointer)
        else $error("read pointer not updated");

    c_legacy_write: cover property (mode_q == MODE_LEGACY && wr_en);
    c_legacy_read: cover property (
        mode_q == MODE_LEGACY && reading_q && sclk_rise &&
        cnt_q == EDGE_COMMIT);
    c_multi_write: cover property (mode_q == MODE_MULTI && wr_en);

endmodule // serial_port_mode_select

/* tb/serial_host_model.sv */
// host serial master driving select, clock and data into the port
// assumes the device samples these pins with a much faster clock
`timescale 1ns/1ps

module serial_host_model #(
    parameter int HALF_NS = 100
) (
    // pins toward the device
    output logic o_select,
    output logic o_sclk,
    output logic o_sdi,
    // read data back from the device
    input wire logic i_sdo
);
    logic last_q;

    // idle: clock stands still low, data shows the inverse of its last bit
    initial begin
        o_select = 1'b0;
        o_sclk = 1'b0;
        o_sdi = 1'b1;
        last_q = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one serial period: data set while clock low, data out taken just
    // before the rise, since the device answers a few fast cycles late
    task automatic bit_cycle(input logic b, output logic rd);
        o_sdi = b;
        last_q = b;
        #(HALF_NS);
        rd = i_sdo;
        o_sclk = 1'b1;
        #(HALF_NS);
        o_sclk = 1'b0;
    endtask

    // legacy frame: rw, six address bits, 24 data bits, commit clock
    task automatic legacy_frame(input logic rw, input logic [5:0] addr,
        input logic [23:0] data, output logic [23:0] rd);
        logic [31:0] f;
        logic b;
        f = {rw, addr, data, data[0]};
        rd = '0;
        o_select = 1'b1;
        #(HALF_NS);
        for (int i = 31; i >= 0; i--) begin
            bit_cycle(f[i], b);
            if (i <= 23) begin
                rd = {rd[22:0], b};
            end
        end
        #(HALF_NS);
        o_select = 1'b0;
        o_sdi = ~last_q;
        #(2 * HALF_NS);
    endtask

    // multi-slave frame: data, register, chip address, then select rise
    task automatic multi_frame(input logic [23:0] data, input logic [4:0] r,
        input logic [2:0] chip, output logic [23:0] rd);
        logic [31:0] f;
        logic b;
        f = {data, r, chip};
        rd = '0;
        for (int i = 31; i >= 0; i--) begin
            bit_cycle(f[i], b);
            if (i >= 8) begin
                rd = {rd[22:0], b};
            end
        end
        #(HALF_NS);
        o_select = 1'b1;
        #(2 * HALF_NS);
        o_select = 1'b0;
        o_sdi = ~last_q;
        #(2 * HALF_NS);
    endtask
endmodule // serial_host_model

/* tb/test_serial_port_mode_select.sv */
// self-checking bench for the serial control port
// assumes the host model file and the design package are compiled first
`timescale 1ns/1ps

module test_serial_port_mode_select;
    import serial_port_mode_pkg::*;

    logic mclk, rst, sel, sclk, serial_data_in, lock, sdo, leg, multi, bias, srst;
    logic [2:0] chip;
    logic [STROBE_W-1:0] strobes, strb_acc;
    logic srst_seen;
    logic [23:0] rd, d;
    logic [31:0] lfsr_q;
    int fail_count, tests_run;
    int model_reg [64];
    logic [5:0] addrs [4] = '{6'h25, 6'h3f, 6'h01, 6'h1e};

    // 40 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    serial_port_mode_select dut_u (
        .i_mclk(mclk), .i_rst(rst), .i_serial_port_select(sel),
        .i_serial_clk(sclk), .i_serial_data_in(serial_data_in),
        .i_chip_address(chip), .i_lock_detect(lock),
        .o_lock_or_read_data_out(sdo), .o_legacy_single_slave_mode(leg),
        .o_multi_slave_mode(multi), .o_bias_enable(bias),
        .o_soft_reset(srst), .o_strobes(strobes));

    serial_host_model host_u (
        .o_select(sel), .o_sclk(sclk), .o_sdi(serial_data_in), .i_sdo(sdo));

    // pulses last one cycle, so gather them between checks
    always @(posedge mclk) begin
        if (srst) begin
            srst_seen <= 1'b1;
        end
        strb_acc <= strb_acc | strobes;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic rnd();
        lfsr_q = lfsr_next(lfsr_q);
        d = lfsr_q[23:0];
    endtask

    // reference register file kept with plain integers
    task automatic model_reset();
        foreach (model_reg[i]) begin
            model_reg[i] = 0;
        end
        model_reg[3] = 'h10;
    endtask

    task automatic model_write(input int a, input int v);
        if (a == 0) begin
            if (v[5]) begin
                model_reset();
            end
        end else begin
            model_reg[a] = v;
        end
    endtask

    function automatic logic [23:0] model_read(input int a);
        return (a == 0) ? CHIP_IDENTIFIER : 24'(model_reg[a]);
    endfunction

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic lwrite(input logic [5:0] a, input logic [23:0] v);
        host_u.legacy_frame(1'b0, a, v, rd);
        model_write(a, v);
    endtask

    task automatic mwrite(input logic [4:0] a, input logic [23:0] v,
        input logic [2:0] c);
        host_u.multi_frame(v, a, c, rd);
        if (c == chip) begin
            model_write(a, v);
        end
    endtask

    task automatic hard_reset();
        @(posedge mclk);
        #1 rst = 1'b1;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        model_reset();
        repeat (4) @(posedge mclk);
        #1;
    endtask

    task automatic print_verdict();
        $display("tests run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard, well past the roughly 150 microseconds the run needs
    initial begin
        #2000000;
        fail_count++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        lock = 1'b1;
        chip = 3'h0;
        srst_seen = 1'b0;
        strb_acc = '0;
        lfsr_q = 32'h4bc654fd;
        fail_count = 0;
        tests_run = 0;
        hard_reset();
        check({20'h0, leg, multi, bias, sdo}, 24'h3);
        // legacy: select first, identifier read, random writes and reads
        host_u.legacy_frame(1'b1, 6'h00, 24'h0, rd);
        check(rd, CHIP_IDENTIFIER);
        check({22'h0, leg, multi}, 24'h2);
        @(posedge mclk);
        #1 lock = 1'b0;
        repeat (2) @(posedge mclk);
        #1 check({23'h0, sdo}, {23'h0, lock});
        foreach (addrs[i]) begin
            rnd();
            lwrite(addrs[i], d);
        end
        foreach (addrs[i]) begin
            host_u.legacy_frame(1'b1, addrs[i], 24'h0, rd);
            check(rd, model_read(addrs[i]));
        end
        lwrite(6'h03, 24'h0);
        check({23'h0, bias}, 24'h0);
        rnd();
        srst_seen = 1'b0;
        strb_acc = '0;
        lwrite(6'h00, {d[23:6], 6'h20});
        check({5'h0, srst_seen, strb_acc}, {5'h0, 1'b1, d[23:6]});
        check({23'h0, bias}, 24'h1);
        host_u.legacy_frame(1'b1, 6'h25, 24'h0, rd);
        check(rd, model_read(6'h25));
        host_u.multi_frame(24'h0, 5'h3, 3'h0, rd);
        check({22'h0, leg, multi}, 24'h2);
        $display("legacy test done");
        // multi-slave: clock first, chip address filtering, pointer reads
        hard_reset();
        rnd();
        chip = d[2:0];
        lock = d[3];
        repeat (4) @(posedge mclk);
        rnd();
        mwrite(5'h07, d, chip);
        check({22'h0, leg, multi}, 24'h1);
        mwrite(5'h03, 24'h0, chip);
        check({23'h0, bias}, 24'h0);
        mwrite(5'h03, 24'h10, chip ^ 3'h1);
        check({23'h0, bias}, 24'h0);
        for (int a = 7; a >= 0; a -= 7) begin
            mwrite(5'h00, 24'(a), chip);
            host_u.multi_frame(24'h0, 5'h3, chip ^ 3'h2, rd);
            check(rd, model_read(a));
        end
        rnd();
        srst_seen = 1'b0;
        strb_acc = '0;
        mwrite(5'h00, {d[23:6], 6'h20}, chip);
        check({5'h0, srst_seen, strb_acc}, {5'h0, 1'b1, d[23:6]});
        check({21'h0, leg, multi, bias}, 24'h3);
        $display("multi test done");
        print_verdict();
    end
endmodule // test_serial_port_mode_select
